// *** src/irq_offset_defs.svh ***
`ifndef IRQ_OFFSET_DEFS_SVH
`define IRQ_OFFSET_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ADDR_INTERRUPT_PIN_ROUTING 8'h2e
`define ADDR_X_AXIS_OFFSET 8'h2f
`define ADDR_Y_AXIS_OFFSET 8'h30
`define ADDR_Z_AXIS_OFFSET 8'h31

// ----------------------------------------------------------------------------
// routing field positions, one bit per function
// ----------------------------------------------------------------------------
`define ROUTE_SLEEP_WAKE_BIT 7
`define ROUTE_FIFO_BIT 6
`define ROUTE_TRANSIENT_BIT 5
`define ROUTE_ORIENTATION_BIT 4
`define ROUTE_PULSE_BIT 3
`define ROUTE_FALL_MOTION_BIT 2
`define ROUTE_SAMPLE_READY_BIT 0

// writable bits of the routing register; bit 1 is unused
`define ROUTING_WRITE_MASK 8'hfd

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ROUTING_RESET 8'h00
`define AXIS_OFFSET_RESET 8'h00
`define UNMAPPED_READ_VALUE 8'h00

// ----------------------------------------------------------------------------
// full-scale range codes for offset scaling
// ----------------------------------------------------------------------------
`define RANGE_2G 2'h0
`define RANGE_4G 2'h1
`define RANGE_8G 2'h2

`endif

// *** src/irq_offset_pkg.sv ***
package irq_offset_pkg;

    // ------------------------------------------------------------------------
    // data carriers
    // ------------------------------------------------------------------------
    typedef logic signed [11:0] sample_t;      // one axis sample, output units
    typedef logic signed [7:0] offset_t;       // one axis offset, 1.96 mg per count

    // three axis samples travelling together
    typedef struct packed {
        sample_t x;
        sample_t y;
        sample_t z;
    } axis_triplet_t;

    // three axis offsets
    typedef struct packed {
        offset_t x;
        offset_t y;
        offset_t z;
    } offset_triplet_t;

    // one interrupt pin, split for a push-pull or open-drain pad
    typedef struct packed {
        logic level;    // value driven when enabled
        logic drive_en; // high while the pad is driven
    } pin_drive_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// *** src/axis_offset_adder.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irq_offset_defs.svh"

// adds one scaled, signed offset to one axis sample and saturates
module axis_offset_adder (
    input wire irq_offset_pkg::sample_t sample_in,
    input wire irq_offset_pkg::offset_t offset_in,
    input wire logic [1:0] range_in,
    output irq_offset_pkg::sample_t sample_out
);

    // ------------------------------------------------------------------------
    // scaling and saturating sum
    // ------------------------------------------------------------------------

    // output lsb is about 1 mg at 2 g, 2 mg at 4 g, 4 mg at 8 g
    always_comb begin
        logic signed [13:0] scaled;
        logic signed [13:0] sum;
        scaled = '0;
        sum = '0;
        case (range_in)
            `RANGE_2G: begin
                scaled = 14'(offset_in) <<< 1; // two counts per offset step
            end
            `RANGE_8G: begin
                scaled = 14'(offset_in) >>> 1; // half a count per step
            end
            default: begin
                scaled = 14'(offset_in);       // one count per step
            end
        endcase
        sum = 14'(sample_in) + scaled;
        // clip at the 12-bit two's-complement limits
        if (sum > 14'sd2047) begin
            sample_out = 12'sh7ff;
        end else if (sum < -14'sd2048) begin
            sample_out = 12'sh800;
        end else begin
            sample_out = sum[11:0];
        end
    end

endmodule // axis_offset_adder

`default_nettype wire

// *** src/interrupt_routing_offset_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irq_offset_defs.svh"

// Overview of operation
// [R1] routing bit clear sends interrupt to pin b
// [R2] routing bit set sends interrupt to pin a
// [R3] routing resets to zero, all to pin b
// [R4] routing bit per function, fixed positions
// [R5] several functions combine onto one pin
// [R6] host reads source register after interrupt
// [R7] three read/write axis offsets at 0x2f-0x31
// [R8] offset shifts each axis zero-g output
// [R9] offsets are signed eight-bit two's complement
// [R10] one offset count equals 1.96 mg
// [R11] axis offsets reset to zero
// [R12] only enabled functions reach the pins
// [R13] level select: clear active low, set high
// [R14] drive select: push-pull or open-drain pins
// [R15] routing bit 1 reads zero, ignores writes
// [R16] scaled offset added before output registers
module interrupt_routing_offset_regs (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // register port from the serial interface
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // function interrupt requests and their enables
    input wire logic [7:0] func_irq_in,
    input wire logic [7:0] irq_enable_in,
    input wire logic irq_level_select_in,
    input wire logic irq_drive_select_in,
    // raw axis samples
    input wire irq_offset_pkg::axis_triplet_t sample_in,
    input wire logic sample_valid_in,
    input wire logic [1:0] range_in,
    // corrected axis samples
    output irq_offset_pkg::axis_triplet_t sample_out,
    output logic sample_valid_out,
    // interrupt pads
    output logic irq_pin_a_out,
    output logic irq_pin_a_oe_out,
    output logic irq_pin_b_out,
    output logic irq_pin_b_oe_out
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------

    // every flip-flop of the block in one record
    typedef struct packed {
        logic [7:0] routing;                      // interrupt_pin_routing
        irq_offset_pkg::offset_triplet_t offsets; // x, y, z axis offsets
        logic [7:0] rdata;                        // read data for the port
        irq_offset_pkg::axis_triplet_t samples;   // corrected samples
        logic samples_valid;                      // corrected sample strobe
        irq_offset_pkg::pin_drive_t pin_a;        // first interrupt pad
        irq_offset_pkg::pin_drive_t pin_b;        // second interrupt pad
    } state_t;

    state_t state_r; // registered state
    state_t state_nxt; // next state

    irq_offset_pkg::reg_req_t req; // bundled register request
    logic [7:0] active_irq; // enabled requests
    logic want_a; // pin a asserted
    logic want_b; // pin b asserted
    irq_offset_pkg::sample_t corrected [3]; // adder results, x y z
    irq_offset_pkg::sample_t raw [3]; // raw samples by index
    irq_offset_pkg::offset_t offs [3]; // offsets by index

    assign req = '{addr: reg_addr_in, wr: reg_wr_in, wdata: reg_wdata_in};

    // ------------------------------------------------------------------------
    // per-axis offset correction
    // ------------------------------------------------------------------------

    // split the carriers into indexed arrays for the generate loop
    assign raw[0] = sample_in.x;
    assign raw[1] = sample_in.y;
    assign raw[2] = sample_in.z;
    assign offs[0] = state_r.offsets.x;
    assign offs[1] = state_r.offsets.y;
    assign offs[2] = state_r.offsets.z;

    // one adder per axis, signed 8-bit offset at 1.96 mg per count
    genvar axis;
    generate
        for (axis = 0; axis < 3; axis = axis + 1) begin : g_axis
            axis_offset_adder u_adder ( // [R8] [R9] [R10]
                .sample_in(raw[axis]),
                .offset_in(offs[axis]),
                .range_in(range_in),
                .sample_out(corrected[axis])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // interrupt routing
    // ------------------------------------------------------------------------

    // gate with enables, then split by routing bit and or together
    always_comb begin
        active_irq = func_irq_in & irq_enable_in; // [R12]
        active_irq[1] = 1'b0; // no function sits at bit 1
        want_a = |(active_irq & state_r.routing); // [R2] [R5]
        want_b = |(active_irq & ~state_r.routing); // [R1] [R5]
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------

    // register writes, read mux, sample path and pad drive
    always_comb begin
        state_nxt = state_r;

        // register writes
        if (req.wr) begin
            case (req.addr)
                `ADDR_INTERRUPT_PIN_ROUTING: begin
                    state_nxt.routing = req.wdata & `ROUTING_WRITE_MASK; // [R4] [R15]
                end
                `ADDR_X_AXIS_OFFSET: begin
                    state_nxt.offsets.x = req.wdata; // [R7]
                end
                `ADDR_Y_AXIS_OFFSET: begin
                    state_nxt.offsets.y = req.wdata; // [R7]
                end
                `ADDR_Z_AXIS_OFFSET: begin
                    state_nxt.offsets.z = req.wdata; // [R7]
                end
                default: begin
                    // other addresses belong elsewhere
                end
            endcase
        end

        // read data follows the address one cycle later
        case (req.addr)
            `ADDR_INTERRUPT_PIN_ROUTING: begin
                state_nxt.rdata = state_r.routing & `ROUTING_WRITE_MASK; // [R15]
            end
            `ADDR_X_AXIS_OFFSET: begin
                state_nxt.rdata = state_r.offsets.x; // [R7]
            end
            `ADDR_Y_AXIS_OFFSET: begin
                state_nxt.rdata = state_r.offsets.y; // [R7]
            end
            `ADDR_Z_AXIS_OFFSET: begin
                state_nxt.rdata = state_r.offsets.z; // [R7]
            end
            default: begin
                state_nxt.rdata = `UNMAPPED_READ_VALUE; // unmapped reads zero
            end
        endcase

        // corrected sample captured on each valid strobe
        state_nxt.samples_valid = sample_valid_in;
        if (sample_valid_in) begin
            state_nxt.samples.x = corrected[0]; // [R16]
            state_nxt.samples.y = corrected[1]; // [R16]
            state_nxt.samples.z = corrected[2]; // [R16]
        end

        // pad drive
        if (irq_drive_select_in) begin
            // open-drain: only ever pull low, release otherwise
            state_nxt.pin_a.level = 1'b0; // [R14]
            state_nxt.pin_b.level = 1'b0; // [R14]
            state_nxt.pin_a.drive_en = (want_a != irq_level_select_in); // [R13] [R14]
            state_nxt.pin_b.drive_en = (want_b != irq_level_select_in); // [R13] [R14]
        end else begin
            // push-pull: always driven, asserted level set by polarity
            state_nxt.pin_a.drive_en = 1'b1; // [R14]
            state_nxt.pin_b.drive_en = 1'b1; // [R14]
            state_nxt.pin_a.level = (want_a == irq_level_select_in); // [R13]
            state_nxt.pin_b.level = (want_b == irq_level_select_in); // [R13]
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------

    // reset: routing and offsets zero, pads push-pull and deasserted low-active
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_r.routing <= `ROUTING_RESET; // [R3]
            state_r.offsets <= {3{`AXIS_OFFSET_RESET}}; // [R11]
            state_r.rdata <= `UNMAPPED_READ_VALUE;
            state_r.samples <= '0;
            state_r.samples_valid <= 1'b0;
            state_r.pin_a <= '{level: 1'b1, drive_en: 1'b1};
            state_r.pin_b <= '{level: 1'b1, drive_en: 1'b1};
        end else begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------

    // every output is a flip-flop of the state record
    assign reg_rdata_out = state_r.rdata;
    assign sample_out = state_r.samples;
    assign sample_valid_out = state_r.samples_valid;
    assign irq_pin_a_out = state_r.pin_a.level;
    assign irq_pin_a_oe_out = state_r.pin_a.drive_en;
    assign irq_pin_b_out = state_r.pin_b.level;
    assign irq_pin_b_oe_out = state_r.pin_b.drive_en;

endmodule // interrupt_routing_offset_regs

`default_nettype wire

// *** sim/interrupt_routing_offset_regs_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "irq_offset_defs.svh"

// ----------------------------------------------------------------------------
// checker of the routing and offset slice
// ----------------------------------------------------------------------------
module irq_offset_checker (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic [7:0] func_irq_in,
    input wire logic [7:0] irq_enable_in,
    input wire logic irq_level_select_in,
    input wire logic irq_drive_select_in,
    input wire irq_offset_pkg::axis_triplet_t sample_out,
    input wire logic sample_valid_in,
    input wire logic sample_valid_out,
    input wire logic irq_pin_a_out,
    input wire logic irq_pin_a_oe_out,
    input wire logic irq_pin_b_out,
    input wire logic irq_pin_b_oe_out
);
    logic [7:0] route_r; // shadow of the routing register
    logic [7:0] live; // enabled requests, unused bit dropped
    logic want_a; // some live request steered to pad a
    logic want_b; // some live request steered to pad b
    assign live = func_irq_in & irq_enable_in & `ROUTING_WRITE_MASK;
    assign want_a = |(live & route_r);
    assign want_b = |(live & ~route_r);
    // shadow follows host writes to the routing register
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            route_r <= `ROUTING_RESET;
        end else if (reg_wr_in && reg_addr_in == `ADDR_INTERRUPT_PIN_ROUTING) begin
            route_r <= reg_wdata_in & `ROUTING_WRITE_MASK;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    // write to an offset, then address held without a write
    sequence s_off_wr; reg_wr_in && reg_addr_in inside {[`ADDR_X_AXIS_OFFSET:`ADDR_Z_AXIS_OFFSET]}; endsequence
    sequence s_hold; !reg_wr_in && $stable(reg_addr_in); endsequence
    chk_pin_a_level: assert property ($past(rstn_in) |->
        irq_pin_a_out == ($past(irq_drive_select_in) ? 1'b0 :
        ($past(want_a) ? $past(irq_level_select_in) : !$past(irq_level_select_in)))) else $error("pad a level off");
    chk_pin_a_drive: assert property ($past(rstn_in) |-> irq_pin_a_oe_out == (!$past(irq_drive_select_in) ||
        ($past(want_a) != $past(irq_level_select_in)))) else $error("pad a enable off");
    chk_pin_b_level: assert property ($past(rstn_in) |->
        irq_pin_b_out == ($past(irq_drive_select_in) ? 1'b0 :
        ($past(want_b) ? $past(irq_level_select_in) : !$past(irq_level_select_in)))) else $error("pad b level off");
    chk_pin_b_drive: assert property ($past(rstn_in) |-> irq_pin_b_oe_out == (!$past(irq_drive_select_in) ||
        ($past(want_b) != $past(irq_level_select_in)))) else $error("pad b enable off");
    chk_route_bit_one: assert property ($past(reg_addr_in) == `ADDR_INTERRUPT_PIN_ROUTING |-> !reg_rdata_out[1])
        else $error("routing bit 1 read set");
    chk_unmapped_zero: assert property (!($past(reg_addr_in) inside {[8'h2e:8'h31]}) |-> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    chk_offset_back: assert property (s_off_wr ##1 s_hold |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("offset readback off");
    chk_route_back: assert property (reg_wr_in && reg_addr_in == `ADDR_INTERRUPT_PIN_ROUTING ##1 s_hold
        |=> reg_rdata_out == ($past(reg_wdata_in, 2) & `ROUTING_WRITE_MASK)) else $error("routing readback off");
    chk_valid_pulse: assert property ($past(rstn_in) |-> sample_valid_out == $past(sample_valid_in))
        else $error("sample strobe not one cycle late");
    chk_data_hold: assert property ($past(rstn_in) && !$past(sample_valid_in) |-> $stable(sample_out))
        else $error("sample changed without strobe");
endmodule // irq_offset_checker

bind interrupt_routing_offset_regs irq_offset_checker irq_offset_checker_inst (.clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .func_irq_in(func_irq_in), .irq_enable_in(irq_enable_in),
    .irq_level_select_in(irq_level_select_in), .irq_drive_select_in(irq_drive_select_in),
    .sample_out(sample_out), .sample_valid_in(sample_valid_in), .sample_valid_out(sample_valid_out),
    .irq_pin_a_out(irq_pin_a_out), .irq_pin_a_oe_out(irq_pin_a_oe_out), .irq_pin_b_out(irq_pin_b_out),
    .irq_pin_b_oe_out(irq_pin_b_oe_out));
`default_nettype wire

// *** sim/irq_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------------
// host side of the interrupt pads, with board pull-ups
// ----------------------------------------------------------------------------
module irq_host_model (
    input wire logic pin_a_in,
    input wire logic pin_a_oe_in,
    input wire logic pin_b_in,
    input wire logic pin_b_oe_in,
    output logic wire_a_out,
    output logic wire_b_out
);
    // a released pad floats up to the pull-up; the host answers a change by reading the source register
    assign wire_a_out = pin_a_oe_in ? pin_a_in : 1'b1;
    assign wire_b_out = pin_b_oe_in ? pin_b_in : 1'b1;
endmodule // irq_host_model
`default_nettype wire

// *** sim/interrupt_routing_offset_regs_test.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end

// ----------------------------------------------------------------------------
// bench of the routing and offset slice
// ----------------------------------------------------------------------------
module interrupt_routing_offset_regs_test;
    logic clk_sys, rstn, wr, lvl, od, vld, vld_out, pa, pa_oe, pb, pb_oe, wa, wb;
    logic [7:0] addr, wdata, rdata, func, en, m;
    logic [1:0] rng;
    irq_offset_pkg::axis_triplet_t smp_in, smp_out;
    int n_mismatch, comparisons;
    int pos [7] = '{7, 6, 5, 4, 3, 2, 0}; // every routed function
    interrupt_routing_offset_regs interrupt_routing_offset_regs_inst (.clk_sys_in(clk_sys), .rstn_in(rstn),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .func_irq_in(func),
        .irq_enable_in(en), .irq_level_select_in(lvl), .irq_drive_select_in(od), .sample_in(smp_in),
        .sample_valid_in(vld), .range_in(rng), .sample_out(smp_out), .sample_valid_out(vld_out),
        .irq_pin_a_out(pa), .irq_pin_a_oe_out(pa_oe), .irq_pin_b_out(pb), .irq_pin_b_oe_out(pb_oe));
    irq_host_model irq_host_model_inst (.pin_a_in(pa), .pin_a_oe_in(pa_oe), .pin_b_in(pb), .pin_b_oe_in(pb_oe),
        .wire_a_out(wa), .wire_b_out(wb));
    // 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // verdict and end of run
    task automatic report_and_stop();
        if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // one register write, strobe held for one edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys); addr = a; wr = 1'b1; wdata = d;
        @(negedge clk_sys); wr = 1'b0;
    endtask
    // one register read, compared against e
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys); addr = a;
        @(negedge clk_sys);
        `CHK("rdata", e, rdata)
    endtask
    // drive requests, then compare pad wire levels one edge on
    task automatic pins(input logic [7:0] f, input logic ea, input logic eb);
        @(negedge clk_sys); func = f;
        @(negedge clk_sys);
        `CHK("pad a", ea ? lvl : ~lvl, wa)
        `CHK("pad b", eb ? lvl : ~lvl, wb)
    endtask
    // one sample strobe and its corrected result
    task automatic smp(input logic [1:0] r, input logic signed [11:0] x, y, z, ex, ey, ez);
        @(negedge clk_sys); rng = r; smp_in.x = x; smp_in.y = y; smp_in.z = z; vld = 1'b1;
        @(negedge clk_sys); vld = 1'b0;
        `CHK("valid", 1'b1, vld_out)
        `CHK("x", ex, smp_out.x)
        `CHK("y", ey, smp_out.y)
        `CHK("z", ez, smp_out.z)
    endtask
    // hang guard
    initial begin
        #200000;
        n_mismatch++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {wr, lvl, od, vld, addr, wdata, func, rng, smp_in} = '0;
        en = 8'hff;
        rstn = 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys); rstn = 1'b1;
        rd_reg(8'h2e, 8'h00);
        for (m = 8'h2f; m <= 8'h31; m++) rd_reg(m, 8'h00);
        smp(2'h1, 12'sd100, -12'sd5, 12'sd7, 12'sd100, -12'sd5, 12'sd7);
        pins(8'h01, 1'b0, 1'b1);
        wr_reg(8'h2e, 8'hff); rd_reg(8'h2e, 8'hfd);
        pins(8'h02, 1'b0, 1'b0);
        wr_reg(8'h2d, 8'h55); rd_reg(8'h2d, 8'h00);
        foreach (pos[i]) begin
            m = 8'h01 << pos[i];
            wr_reg(8'h2e, m); rd_reg(8'h2e, m);
            pins(m, 1'b1, 1'b0);
            pins(~m, 1'b0, 1'b1);
        end
        wr_reg(8'h2e, 8'h0c);
        pins(8'h0c, 1'b1, 1'b0); pins(8'h08, 1'b1, 1'b0);
        en = 8'h00; pins(8'hff, 1'b0, 1'b0); en = 8'hff;
        lvl = 1'b1; pins(8'h04, 1'b1, 1'b0); pins(8'h01, 1'b0, 1'b1);
        od = 1'b1; pins(8'h04, 1'b1, 1'b0); lvl = 1'b0; pins(8'h01, 1'b0, 1'b1);
        od = 1'b0;
        wr_reg(8'h2f, 8'hfd); wr_reg(8'h30, 8'h7f); wr_reg(8'h31, 8'h80);
        rd_reg(8'h2f, 8'hfd); rd_reg(8'h30, 8'h7f); rd_reg(8'h31, 8'h80);
        smp(2'h1, 12'sd100, 12'sd2040, -12'sd2000, 12'sd97, 12'sd2047, 12'sh800);
        smp(2'h0, 12'sd100, 12'sd0, 12'sd0, 12'sd94, 12'sd254, -12'sd256);
        smp(2'h2, 12'sd100, 12'sd0, 12'sd0, 12'sd98, 12'sd63, -12'sd64);
        smp(2'h3, 12'sd100, 12'sd0, 12'sd0, 12'sd97, 12'sd127, -12'sd128);
        // reset in mid-run clears routing and offsets that were written
        @(negedge clk_sys); rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        rd_reg(8'h2e, 8'h00);
        for (m = 8'h2f; m <= 8'h31; m++) rd_reg(m, 8'h00);
        pins(8'h04, 1'b0, 1'b1);
        // host answers the asserted pad by reading the source register, held outside this slice
        rd_reg(8'h0c, 8'h00);
        report_and_stop();
    end
endmodule // interrupt_routing_offset_regs_test
`undef CHK
`default_nettype wire
